// [shp_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module shp_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  for (genvar i = 0; i < D; i++) begin : g_ent
    always_comb begin
      mem_nxt[i] = (push && wp_r == PW'(i)) ? in_data : mem_r[i];
    end
  end

  // depth is taken as a power of two so the pointers wrap by themselves
  always_comb begin
    wp_nxt = push ? PW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? PW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = CW'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = CW'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce) begin
      mem_r <= mem_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// [shp_host_model.sv]
// host cpu model that drives the sram-like pins of the port
`timescale 1ns/1ns
module shp_host_model #(
  parameter logic [5:0] ENDIAN_IDX = 6'h19
) (
  input wire logic ref_clk,
  input wire logic [shp_pkg::HOST_W-1:0] data_pin,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [shp_pkg::ADDR_W-1:0] host_addr,
  output logic data_sel,
  output logic [shp_pkg::HOST_W-1:0] host_drv,
  output logic host_drv_oe
);
  import shp_pkg::*;
  // strict off lets a scenario write before the first read on purpose
  bit strict = 1'b1;
  bit read_done = 1'b0;
  logic [HOST_W-1:0] junk;
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_addr = 7'h00;
    data_sel = 1'b0;
    host_drv = 16'h0000;
    host_drv_oe = 1'b0;
  end
  // strobe held 6 clocks, then 4 idle clocks before the next access
  task automatic acc(input bit rd, input bit cs, input logic [6:0] a,
                     input bit ds, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge ref_clk);
    #1;
    host_addr = a;
    data_sel = ds;
    host_drv = d;
    host_drv_oe = !rd;
    chip_select_n = !cs;
    if (rd) read_strobe_n = 1'b0;
    else write_strobe_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    q = data_pin;
    if (rd && cs) read_done = 1'b1;
    #1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    host_drv_oe = 1'b0;
  endtask
  task automatic rd(input bit cs, input logic [6:0] a, input bit ds,
                    output logic [15:0] q);
    acc(1'b1, cs, a, ds, 16'h0000, q);
  endtask
  task automatic wr(input bit cs, input logic [6:0] a, input bit ds,
                    input logic [15:0] d);
    if (strict && !read_done) acc(1'b1, 1'b1, {ENDIAN_IDX, 1'b0}, 1'b0,
                                  16'h0000, junk);
    acc(1'b0, cs, a, ds, d, junk);
  endtask
  // waking write goes to the endian test register, then a read is owed
  task automatic wake_up();
    acc(1'b0, 1'b1, {ENDIAN_IDX, 1'b1}, 1'b0, 16'h0000, junk);
    read_done = 1'b0;
  endtask
endmodule

// [shp_host_port.sv]
// sram-like 16-bit host port with 32-bit fifo and csr paths
`timescale 1ns/1ns
module shp_host_port (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [shp_pkg::ADDR_W-1:0] host_addr,
  input wire logic data_sel,
  input wire logic [shp_pkg::HOST_W-1:0] host_data_in,
  output logic [shp_pkg::HOST_W-1:0] host_data_out,
  output logic host_data_oe,
  input wire logic big_endian,
  input wire logic low_power,
  output logic wake,
  output logic [shp_pkg::WORD_W-1:0] tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_space,
  output logic tx_overrun,
  input wire logic [shp_pkg::WORD_W-1:0] rx_word,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [shp_pkg::CSR_IDX_W-1:0] csr_index,
  output logic [shp_pkg::WORD_W-1:0] csr_wdata,
  output logic csr_wr,
  output logic csr_rd,
  input wire logic [shp_pkg::WORD_W-1:0] csr_rdata,
  input wire logic [shp_pkg::IRQ_N-1:0] irq_events,
  input wire logic [shp_pkg::IRQ_N-1:0] irq_enable,
  input wire logic irq_active_high,
  input wire logic irq_open_drain,
  output logic irq_out,
  output logic irq_oe
);
  import shp_pkg::*;

  logic [PIN_W-1:0] sync1_r, sync2_r;
  logic cs_n_s, rd_n_s, wr_n_s, sel_s;
  logic [ADDR_W-1:0] addr_s;
  logic [HOST_W-1:0] din_s;
  logic rd_act, wr_act, is_data, csr_half, irq_lvl;
  shp_state_t state_r, state_nxt;
  logic half_wr_r, half_wr_nxt, half_rd_r, half_rd_nxt;
  logic rd_half_r, rd_half_nxt, read_seen_r, read_seen_nxt;
  logic wt_ok_r, wt_ok_nxt, wt_data_r, wt_data_nxt, wt_half_r, wt_half_nxt;
  logic [CSR_IDX_W-1:0] wt_idx_r, wt_idx_nxt, csr_idx_r, csr_idx_nxt;
  logic [HOST_W-1:0] wdata_r, wdata_nxt, lo_hold_r, lo_hold_nxt;
  logic [HOST_W-1:0] csr_hold_r, csr_hold_nxt, rx_hold_r, rx_hold_nxt;
  logic [HOST_W-1:0] dout_r, dout_nxt;
  logic [WORD_W-1:0] push_word_r, push_word_nxt, csr_wd_r, csr_wd_nxt;
  logic push_valid_r, push_valid_nxt, csr_wr_r, csr_wr_nxt;
  logic csr_rd_r, csr_rd_nxt, wake_r, wake_nxt, oe_r, oe_nxt;
  logic ovr_r, ovr_nxt, irq_r, irq_nxt, irq_oe_r, irq_oe_nxt;

  // host pins are asynchronous; the data bus may tear while it settles, so
  // write data is taken from the last cycle the strobe was still seen low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
    end else if (clk_en) begin
      sync1_r <= {chip_select_n, read_strobe_n, write_strobe_n, data_sel,
                  host_addr, host_data_in};
      sync2_r <= sync1_r;
    end
  end
  assign {cs_n_s, rd_n_s, wr_n_s, sel_s, addr_s, din_s} = sync2_r;

  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_act = ~cs_n_s & ~wr_n_s & rd_n_s;
  // a7..a1 ignored under data select; direction picks rx or tx
  assign is_data = sel_s | (addr_s[6:5] == DATA_REGION);
  assign csr_half = addr_s[0] ^ big_endian;
  assign irq_lvl = |(irq_events & irq_enable);

  assign rx_ready = clk_en & (state_r == ST_IDLE) & rd_act & is_data &
                    ~half_rd_r & rx_valid;

  shp_fifo #(
    .W(WORD_W),
    .D(TX_DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(clk_en),
    .in_valid(push_valid_r),
    .in_ready(tx_space),
    .in_data(push_word_r),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_word)
  );

  always_comb begin
    state_nxt = state_r;
    half_wr_nxt = half_wr_r;
    half_rd_nxt = half_rd_r;
    rd_half_nxt = rd_half_r;
    read_seen_nxt = read_seen_r;
    wt_ok_nxt = wt_ok_r;
    wt_data_nxt = wt_data_r;
    wt_half_nxt = wt_half_r;
    wt_idx_nxt = wt_idx_r;
    csr_idx_nxt = csr_idx_r;
    wdata_nxt = wdata_r;
    lo_hold_nxt = lo_hold_r;
    csr_hold_nxt = csr_hold_r;
    rx_hold_nxt = rx_hold_r;
    dout_nxt = dout_r;
    push_word_nxt = push_word_r;
    csr_wd_nxt = csr_wd_r;
    push_valid_nxt = 1'b0;
    csr_wr_nxt = 1'b0;
    csr_rd_nxt = 1'b0;
    wake_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (rd_act) begin
          state_nxt = ST_RD;
          read_seen_nxt = 1'b1;
          if (is_data) begin
            if (half_rd_r) begin
              dout_nxt = rx_hold_r;
              half_rd_nxt = 1'b0;
            end else if (rx_valid) begin
              dout_nxt = rx_word[15:0];
              rx_hold_nxt = rx_word[31:16];
              half_rd_nxt = 1'b1;
            end else begin
              dout_nxt = DOUT_EMPTY;
            end
          end else begin
            csr_rd_nxt = 1'b1;
            csr_idx_nxt = addr_s[6:1];
            rd_half_nxt = csr_half;
          end
        end else if (wr_act) begin
          state_nxt = ST_WR;
          wake_nxt = low_power;
          // the waking write itself is dropped; a read must come first
          wt_ok_nxt = read_seen_r & ~low_power;
          if (low_power) begin
            read_seen_nxt = 1'b0;
          end
          wt_data_nxt = is_data;
          wt_half_nxt = csr_half;
          wt_idx_nxt = addr_s[6:1];
          wdata_nxt = din_s;
        end
      end
      ST_RD: begin
        if (!rd_act) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR: begin
        if (wr_act) begin
          wdata_nxt = din_s;
        end else begin
          state_nxt = ST_IDLE;
          if (wt_ok_r && wt_data_r) begin
            if (!half_wr_r) begin
              lo_hold_nxt = wdata_r;
              half_wr_nxt = 1'b1;
            end else begin
              push_valid_nxt = 1'b1;
              push_word_nxt = {wdata_r, lo_hold_r};
              half_wr_nxt = 1'b0;
            end
          end else if (wt_ok_r) begin
            if (!wt_half_r) begin
              csr_hold_nxt = wdata_r;
            end else begin
              csr_wr_nxt = 1'b1;
              csr_wd_nxt = {wdata_r, csr_hold_r};
              csr_idx_nxt = wt_idx_r;
            end
          end
        end
      end
    endcase
    if (csr_rd_r) begin
      dout_nxt = rd_half_r ? csr_rdata[31:16] : csr_rdata[15:0];
    end
    // the host has no wait pin, so a full tx fifo loses the word
    ovr_nxt = push_valid_r & ~tx_space;
    oe_nxt = rd_act;
    irq_nxt = irq_active_high ? irq_lvl : ~irq_lvl;
    irq_oe_nxt = ~irq_open_drain | ~irq_nxt;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      half_wr_r <= 1'b0;
      half_rd_r <= 1'b0;
      rd_half_r <= 1'b0;
      read_seen_r <= 1'b0;
      wt_ok_r <= 1'b0;
      wt_data_r <= 1'b0;
      wt_half_r <= 1'b0;
      wt_idx_r <= CSR_IDX_RST;
      csr_idx_r <= CSR_IDX_RST;
      wdata_r <= DOUT_RST;
      lo_hold_r <= DOUT_RST;
      csr_hold_r <= DOUT_RST;
      rx_hold_r <= DOUT_RST;
      dout_r <= DOUT_RST;
      push_word_r <= WORD_RST;
      csr_wd_r <= WORD_RST;
      push_valid_r <= 1'b0;
      csr_wr_r <= 1'b0;
      csr_rd_r <= 1'b0;
      wake_r <= 1'b0;
      oe_r <= 1'b0;
      ovr_r <= 1'b0;
      irq_r <= 1'b0;
      irq_oe_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      half_wr_r <= half_wr_nxt;
      half_rd_r <= half_rd_nxt;
      rd_half_r <= rd_half_nxt;
      read_seen_r <= read_seen_nxt;
      wt_ok_r <= wt_ok_nxt;
      wt_data_r <= wt_data_nxt;
      wt_half_r <= wt_half_nxt;
      wt_idx_r <= wt_idx_nxt;
      csr_idx_r <= csr_idx_nxt;
      wdata_r <= wdata_nxt;
      lo_hold_r <= lo_hold_nxt;
      csr_hold_r <= csr_hold_nxt;
      rx_hold_r <= rx_hold_nxt;
      dout_r <= dout_nxt;
      push_word_r <= push_word_nxt;
      csr_wd_r <= csr_wd_nxt;
      push_valid_r <= push_valid_nxt;
      csr_wr_r <= csr_wr_nxt;
      csr_rd_r <= csr_rd_nxt;
      wake_r <= wake_nxt;
      oe_r <= oe_nxt;
      ovr_r <= ovr_nxt;
      irq_r <= irq_nxt;
      irq_oe_r <= irq_oe_nxt;
    end
  end

  assign host_data_out = dout_r;
  assign host_data_oe = oe_r;
  assign wake = wake_r;
  assign tx_overrun = ovr_r;
  assign csr_index = csr_idx_r;
  assign csr_wdata = csr_wd_r;
  assign csr_wr = csr_wr_r;
  assign csr_rd = csr_rd_r;
  assign irq_out = irq_r;
  assign irq_oe = irq_oe_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || !clk_en);

  AST_OE_IN_READ: assert property (
    host_data_oe |-> $past(!chip_select_n && !read_strobe_n, 3))
    else $error("data bus driven outside a selected read");
  AST_CS_IGNORED: assert property (
    $past(chip_select_n, 3) |-> state_r == ST_IDLE && !host_data_oe)
    else $error("access seen while chip select high");
  AST_WAKE_ON_WRITE: assert property (
    (state_r == ST_IDLE && wr_act && low_power) |=> wake)
    else $error("write in low power did not wake");
  AST_WAKE_CAUSE: assert property (
    wake |-> $past(low_power) && $past(state_r == ST_IDLE))
    else $error("wake without a low power write");
  AST_PUSH_PAIR: assert property (
    push_valid_r |-> $past(half_wr_r) && !half_wr_r &&
                     push_word_r[15:0] == $past(lo_hold_r))
    else $error("tx word not built from two halves");
  AST_SEL_FIFO: assert property (
    (state_r == ST_IDLE && rd_act && sel_s) |=> !csr_rd)
    else $error("csr read under data select");
  AST_CSR_DECODE: assert property (
    (state_r == ST_IDLE && rd_act && !is_data) |=>
      csr_rd && csr_index == $past(addr_s[6:1]))
    else $error("csr read not decoded from address");
  AST_CSR_HALF: assert property (
    csr_rd |=> host_data_out == ($past(rd_half_r) ?
      $past(csr_rdata[31:16]) : $past(csr_rdata[15:0])))
    else $error("wrong csr half on data bus");
  AST_BE_SWAP: assert property (
    (state_r == ST_IDLE && rd_act && !is_data && big_endian) |=>
      rd_half_r == !$past(addr_s[0]))
    else $error("big endian half not swapped");
  AST_RX_LOW: assert property (
    rx_ready |=> host_data_out == $past(rx_word[15:0]))
    else $error("rx low half not presented");
  AST_IRQ_POL: assert property (
    irq_lvl |=> irq_out == $past(irq_active_high))
    else $error("irq level has wrong polarity");
  AST_IRQ_OD: assert property (
    irq_oe |-> !($past(irq_open_drain) && irq_out))
    else $error("open drain irq drove high");

  COV_TX_WORD: cover property (push_valid_r);
  COV_CSR_WR: cover property (csr_wr);
  COV_WAKE: cover property (wake);
  COV_RX_PAIR: cover property (rx_ready ##[1:40]
    (state_r == ST_IDLE && rd_act && is_data && half_rd_r));
endmodule

// [shp_pkg.sv]
// shared constants and types for the sram-like host port
package shp_pkg;
  localparam int HOST_W = 16;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 7;
  localparam int CSR_IDX_W = 6;
  localparam int TX_DEPTH = 4;
  localparam int IRQ_N = 8;
  localparam int PIN_W = 3 + 1 + ADDR_W + HOST_W;
  // cs, read and write strobes idle high in the synchroniser after reset
  localparam logic [PIN_W-1:0] PIN_RST = 27'h7000000;
  // upper two address bits (a7, a6) of the data-fifo window
  localparam logic [1:0] DATA_REGION = 2'h0;
  localparam logic [HOST_W-1:0] DOUT_RST = 16'h0000;
  localparam logic [HOST_W-1:0] DOUT_EMPTY = 16'h0000;
  localparam logic [CSR_IDX_W-1:0] CSR_IDX_RST = 6'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b100
  } shp_state_t;
endpackage

// [tb.sv]
// self-checking bench for the sram-like host port
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
  import shp_pkg::*;
  logic ref_clk = 0, reset = 1, big_endian = 0, low_power = 0, clk_en = 1;
  logic cs_n, rd_n, wr_n, ds, h_oe, d_oe, tx_valid, tx_ready = 0;
  logic tx_space, tx_ovr, rx_valid = 0, rx_ready, csr_wr, csr_rd, wake;
  logic [6:0] addr;
  logic [15:0] h_drv, d_out, pin_last = 16'h0000, data_pin, q;
  logic [31:0] tx_word, rx_word = 32'h89abcdef, csr_wdata, csr_rdata;
  logic [5:0] csr_index;
  logic [7:0] irq_events = 8'h24, irq_enable = 8'h00;
  logic irq_ah = 0, irq_od = 0, irq_out, irq_oe;
  int mismatches = 0, tests_run = 0;
  int n_wake = 0, n_wr = 0, n_ovr = 0, n_pop = 0, n_oe = 0, n_crd = 0;
  logic [31:0] last_wd;
  always #5 ref_clk = ~ref_clk;
  // a released bus shows the inverse of its last level, never a held value
  assign data_pin = d_oe ? d_out : (h_oe ? h_drv : ~pin_last);
  assign csr_rdata = {csr_index, 10'h0a5, csr_index, 10'h05a};
  always @(posedge ref_clk) begin
    pin_last <= data_pin;
    if (wake) n_wake++;
    if (tx_ovr) n_ovr++;
    if (d_oe) n_oe++;
    if (csr_rd) n_crd++;
    if (csr_wr) begin
      n_wr++;
      last_wd = csr_wdata;
    end
    if (rx_ready) begin
      n_pop++;
      rx_word <= 32'h13572468;
    end
  end
  shp_host_model i_host (.ref_clk(ref_clk), .data_pin(data_pin),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .host_addr(addr), .data_sel(ds), .host_drv(h_drv), .host_drv_oe(h_oe));
  shp_host_port i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .host_addr(addr), .data_sel(ds), .host_data_in(data_pin),
    .host_data_out(d_out), .host_data_oe(d_oe), .big_endian(big_endian),
    .low_power(low_power), .wake(wake), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_space(tx_space),
    .tx_overrun(tx_ovr), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .csr_index(csr_index), .csr_wdata(csr_wdata),
    .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_rdata(csr_rdata),
    .irq_events(irq_events), .irq_enable(irq_enable),
    .irq_active_high(irq_ah), .irq_open_drain(irq_od), .irq_out(irq_out),
    .irq_oe(irq_oe));
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_no_read();
    i_host.strict = 1'b0;
    i_host.wr(1'b1, 7'h00, 1'b0, 16'haaaa);
    i_host.wr(1'b1, 7'h00, 1'b0, 16'hbbbb);
    `CHK(tx_valid, 1'b0);
    i_host.strict = 1'b1;
  endtask
  task automatic t_rx();
    rx_valid = 1'b1;
    i_host.rd(1'b1, 7'h00, 1'b0, q);
    `CHK(q, 16'hcdef);
    i_host.rd(1'b1, 7'h7c, 1'b1, q);
    `CHK(q, 16'h89ab);
    `CHK(n_pop, 1);
    rx_valid = 1'b0;
    i_host.rd(1'b1, 7'h00, 1'b0, q);
    `CHK(q, 16'h0000);
    `CHK(d_oe, 1'b0);
  endtask
  task automatic t_tx();
    tx_ready = 1'b0;
    for (int k = 0; k < 5; k++) begin
      i_host.wr(1'b1, k[0] ? 7'h7c : 7'h00, k[0], 16'h1000 + 16'(k));
      i_host.wr(1'b1, 7'h00, 1'b0, 16'h2000 + 16'(k));
      if (k == 3) `CHK(tx_space, 1'b0);
    end
    // the overrun pulse follows the dropped push by one clock
    @(posedge ref_clk);
    #1;
    `CHK(n_ovr, 1);
    for (int k = 0; k < 4; k++) begin
      `CHK(tx_word, {16'h2000 + 16'(k), 16'h1000 + 16'(k)});
      @(posedge ref_clk);
      #1 tx_ready = 1'b1;
      @(posedge ref_clk);
      #1 tx_ready = 1'b0;
    end
    `CHK(tx_valid, 1'b0);
  endtask
  task automatic t_csr();
    for (int be = 0; be < 2; be++) begin
      big_endian = be[0];
      i_host.wr(1'b1, {6'h25, be[0]}, 1'b0, 16'h3344 + 16'(be));
      `CHK(n_wr, be);
      i_host.wr(1'b1, {6'h25, !be[0]}, 1'b0, 16'h5566);
      `CHK(n_wr, be + 1);
      `CHK(last_wd, {16'h5566, 16'h3344 + 16'(be)});
      for (int a1 = 0; a1 < 2; a1++) begin
        i_host.rd(1'b1, {6'h31, a1[0]}, 1'b0, q);
        `CHK(q, (a1[0] ^ be[0]) ? 16'hc4a5 : 16'hc45a);
      end
    end
    `CHK(n_crd, 4);
    big_endian = 1'b0;
  endtask
  task automatic t_cs_high();
    int oe0;
    oe0 = n_oe;
    i_host.rd(1'b0, 7'h62, 1'b0, q);
    i_host.wr(1'b0, 7'h4b, 1'b0, 16'h1234);
    i_host.wr(1'b0, 7'h00, 1'b0, 16'h5678);
    i_host.wr(1'b0, 7'h00, 1'b0, 16'h9abc);
    `CHK(n_oe, oe0);
    `CHK(n_crd, 4);
    `CHK(n_wr, 2);
    `CHK(tx_valid, 1'b0);
  endtask
  task automatic t_wake();
    low_power = 1'b1;
    i_host.wake_up();
    `CHK(n_wake, 1);
    `CHK(n_wr, 2);
    low_power = 1'b0;
    i_host.wr(1'b1, 7'h00, 1'b0, 16'h0001);
    i_host.wr(1'b1, 7'h00, 1'b0, 16'h0002);
    `CHK(tx_word, 32'h00020001);
  endtask
  // clock enable low must hold the fifo and the irq pin still
  task automatic t_freeze();
    clk_en = 1'b0;
    tx_ready = 1'b1;
    irq_enable = 8'h04;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(tx_valid, 1'b1);
    `CHK(irq_out, 1'b1);
    clk_en = 1'b1;
    @(posedge ref_clk);
    #1 tx_ready = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(tx_valid, 1'b0);
    `CHK(irq_out, 1'b0);
  endtask
  task automatic t_irq();
    logic o;
    for (int i = 0; i < 8; i++) begin
      irq_ah = i[0];
      irq_od = i[1];
      irq_enable = i[2] ? 8'h04 : 8'h08;
      repeat (3) @(posedge ref_clk);
      #1;
      o = i[2] ? i[0] : !i[0];
      `CHK(irq_out, o);
      `CHK(irq_oe, i[1] ? !o : 1'b1);
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 reset = 1'b0;
    `CHK(d_oe, 1'b0);
    `CHK(tx_space, 1'b1);
    t_no_read();
    t_rx();
    t_tx();
    t_csr();
    t_cs_high();
    t_wake();
    t_freeze();
    t_irq();
    complete_run();
  end
  // whole run needs under 1500 clocks, so 30000 means a hang
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
endmodule
